// ==== include/fpec_pkg.sv ====
// constants for the flash program/erase control block
package fpec_pkg;

	// register byte addresses on the apb bus
	localparam logic [7:0] ADDR_MODE   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_EBS    = 8'h08;
	localparam logic [7:0] ADDR_ACCEN  = 8'h0C;
	localparam logic [7:0] ADDR_IRQST  = 8'h10;
	localparam logic [7:0] ADDR_IRQMSK = 8'h14;

	// flash_mode_control bit positions
	localparam int BIT_WRITE_EN     = 6;
	localparam int BIT_ERASE_SETUP  = 5;
	localparam int BIT_PROG_SETUP   = 4;
	localparam int BIT_ERASE_VERIFY = 3;
	localparam int BIT_PROG_VERIFY  = 2;
	localparam int BIT_E            = 1;
	localparam int BIT_P            = 0;

	// flash_status and access enable bit positions
	localparam int BIT_ERROR = 7;
	localparam int BIT_ACCEN = 7;

	// interrupt status bit positions
	localparam int IRQ_ERR = 0;
	localparam int IRQ_REJ = 1;
	localparam int IRQ_W   = 2;

	// reset values
	localparam logic [7:0] RST_MODE  = 8'h00;
	localparam logic [6:0] RST_EBS   = 7'h00;
	localparam logic [1:0] RST_IRQ   = 2'h0;
	localparam int         EBS_W     = 7;

	// true when the byte address names one of the block's registers
	function automatic logic fpec_addr_hit(input logic [7:0] a);
		return (a == ADDR_MODE) || (a == ADDR_STATUS) || (a == ADDR_EBS)
			|| (a == ADDR_ACCEN) || (a == ADDR_IRQST) || (a == ADDR_IRQMSK);
	endfunction : fpec_addr_hit

	// true for the flash control registers gated by access enable
	function automatic logic fpec_gated(input logic [7:0] a);
		return (a == ADDR_MODE) || (a == ADDR_STATUS) || (a == ADDR_EBS);
	endfunction : fpec_gated

endpackage : fpec_pkg

// ==== include/fpec_regs_if.sv ====
// register access strobes between the apb front end and the core
`timescale 1ns/1ps
interface fpec_regs_if;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic [31:0] rdata;

	modport front
	(
		output addr,
		output wdata,
		output wr,
		input  rdata
	);

	modport core
	(
		input  addr,
		input  wdata,
		input  wr,
		output rdata
	);
endinterface : fpec_regs_if

// ==== hw/fpec_apb.sv ====
// apb slave front end: one wait state, registered answer
`timescale 1ns/1ps
module fpec_apb
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// core side
	fpec_regs_if.front       regs
);

	logic access;
	logic hit;

	// first access cycle: answer is prepared here, shown on the next
	assign access = psel && penable && !pready;
	assign hit    = fpec_pkg::fpec_addr_hit(paddr[7:0]) && (paddr[31:8] == 24'h000000);

	assign regs.addr  = paddr[7:0];
	assign regs.wdata = pwdata;
	// write lands at the edge where the master sees pready
	assign regs.wr    = psel && penable && pready && pwrite && !pslverr;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= access;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= access && !hit;
	end

	// read data latched so it stays put while pready is high
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (access)
			prdata <= (!pwrite && hit) ? regs.rdata : 32'h00000000;
	end

endmodule : fpec_apb

// ==== hw/fpec_top.sv ====
// flash program/erase mode control with status, protection and interrupt
//
// What this block does
// - program and erase modes only possible while software_write_enable is one
// - with software_write_enable zero, other mode bits and block select ignore writes
// - erase_setup bit enters and leaves erase setup; set before erase bit
// - program_setup bit enters and leaves program setup; set before program bit
// - erase_verify bit high means erase-verify mode; clearing leaves it
// - program_verify bit high means program-verify mode; clearing leaves it
// - erase bit enters erase mode only with enable and erase_setup; clear cancels
// - program bit enters program mode only with enable and program_setup; clear cancels
// - flash_error_flag sets on a fault during program or erase
// - error flag high puts the array in error protection, blocking program and erase
// - mode bit 7 and status bits 6 to 0 always read zero
// - erase_block_select held at zero while software_write_enable is zero
// - control registers reachable only while control_access_enable is one
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module fpec_top
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// flash array
	input  wire logic        array_fault,
	output logic             program_mode,
	output logic             erase_mode,
	output logic             program_setup_state,
	output logic             erase_setup_state,
	output logic             program_verify_mode,
	output logic             erase_verify_mode,
	output logic [6:0]       erase_block_select,
	output logic             error_protect,
	// interrupt
	output logic             irq
);

	fpec_regs_if regs ();

	fpec_apb fpec_apb_i
	(
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.regs    (regs.front)
	);

	// registers with no port; each mode bit but software_write_enable is the output flop of that mode
	logic       software_write_enable;
	logic       flash_error_flag;
	logic       control_access_enable;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;

	logic       ctl_open;
	logic       wr_mode;
	logic       wr_ebs;
	logic       wr_accen;
	logic       wr_irqst;
	logic       wr_irqmsk;
	logic [7:0] wd;
	logic       keep_on;
	logic       fault_event;
	logic       reject_event;
	logic [1:0] irq_set;
	logic [6:0] ebs_hot;

	logic       next_program;
	logic       next_erase;
	logic [6:0] next_ebs;

	assign wd       = regs.wdata[7:0];
	assign ctl_open = control_access_enable;

	// gated registers take no write while access is closed
	assign wr_mode   = regs.wr && ctl_open && (regs.addr == fpec_pkg::ADDR_MODE);
	assign wr_ebs    = regs.wr && ctl_open && (regs.addr == fpec_pkg::ADDR_EBS);
	assign wr_accen  = regs.wr && (regs.addr == fpec_pkg::ADDR_ACCEN);
	assign wr_irqst  = regs.wr && (regs.addr == fpec_pkg::ADDR_IRQST);
	assign wr_irqmsk = regs.wr && (regs.addr == fpec_pkg::ADDR_IRQMSK);
	// flash_status has no write path at all: writes land nowhere

	// other bits only take while enable was already one and stays one
	assign keep_on = software_write_enable && wd[fpec_pkg::BIT_WRITE_EN];

	// erase needs setup already standing; protection blocks it outright
	always_comb
	begin
		next_erase = erase_mode;
		if (flash_error_flag)
			next_erase = 1'b0;
		else if (wr_mode)
			next_erase = keep_on && wd[fpec_pkg::BIT_E]
				&& (erase_mode || erase_setup_state);
	end

	always_comb
	begin
		next_program = program_mode;
		if (flash_error_flag)
			next_program = 1'b0;
		else if (wr_mode)
			next_program = keep_on && wd[fpec_pkg::BIT_P]
				&& (program_mode || program_setup_state);
	end

	// more than one block selected clears the whole selection
	assign ebs_hot = wd[6:0];

	always_comb
	begin
		next_ebs = erase_block_select;
		if (wr_ebs && software_write_enable)
		begin
			if ($countones(ebs_hot) > 1)
				next_ebs = fpec_pkg::RST_EBS;
			else
				next_ebs = ebs_hot;
		end
		if (!software_write_enable || (wr_mode && !wd[fpec_pkg::BIT_WRITE_EN]))
			next_ebs = fpec_pkg::RST_EBS;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			software_write_enable <= 1'b0;
		else if (wr_mode)
			software_write_enable <= wd[fpec_pkg::BIT_WRITE_EN];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			erase_setup_state <= 1'b0;
		else if (wr_mode)
			erase_setup_state <= keep_on && wd[fpec_pkg::BIT_ERASE_SETUP];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			program_setup_state <= 1'b0;
		else if (wr_mode)
			program_setup_state <= keep_on && wd[fpec_pkg::BIT_PROG_SETUP];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			erase_verify_mode <= 1'b0;
		else if (wr_mode)
			erase_verify_mode <= keep_on && wd[fpec_pkg::BIT_ERASE_VERIFY];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			program_verify_mode <= 1'b0;
		else if (wr_mode)
			program_verify_mode <= keep_on && wd[fpec_pkg::BIT_PROG_VERIFY];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			erase_mode <= 1'b0;
		else
			erase_mode <= next_erase;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			program_mode <= 1'b0;
		else
			program_mode <= next_program;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			erase_block_select <= fpec_pkg::RST_EBS;
		else
			erase_block_select <= next_ebs;
	end

	// error is sticky until reset; no software path clears it
	assign fault_event = array_fault && (program_mode || erase_mode);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flash_error_flag <= 1'b0;
		else if (fault_event)
			flash_error_flag <= 1'b1;
	end

	// separate flop so the protection output is a clean register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			error_protect <= 1'b0;
		else if (fault_event)
			error_protect <= 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			control_access_enable <= 1'b0;
		else if (wr_accen)
			control_access_enable <= wd[fpec_pkg::BIT_ACCEN];
	end

	// a write while enable is low that tries to set mode bits 5 to 0 or any block select bit is flagged
	assign reject_event = software_write_enable == 1'b0
		&& ((wr_mode && (wd[5:0] != 6'h00)) || (wr_ebs && (wd[6:0] != 7'h00)));

	assign irq_set[fpec_pkg::IRQ_ERR] = fault_event && !flash_error_flag;
	assign irq_set[fpec_pkg::IRQ_REJ] = reject_event;

	// write one to clear; a new event in the same cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_status <= fpec_pkg::RST_IRQ;
		else if (wr_irqst)
			irq_status <= (irq_status & ~regs.wdata[1:0]) | irq_set;
		else
			irq_status <= irq_status | irq_set;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask <= fpec_pkg::RST_IRQ;
		else if (wr_irqmsk)
			irq_mask <= regs.wdata[1:0];
	end

	// rises at the same edge as the status bit, kept a flop for a glitch-free pin
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |((irq_status | irq_set) & irq_mask);
	end

	// read mux; gated registers read zero while access is closed
	always_comb
	begin
		regs.rdata = 32'h00000000;
		unique case (regs.addr)
			fpec_pkg::ADDR_MODE:
			begin
				if (ctl_open)
				begin
					regs.rdata[fpec_pkg::BIT_WRITE_EN]     = software_write_enable;
					regs.rdata[fpec_pkg::BIT_ERASE_SETUP]  = erase_setup_state;
					regs.rdata[fpec_pkg::BIT_PROG_SETUP]   = program_setup_state;
					regs.rdata[fpec_pkg::BIT_ERASE_VERIFY] = erase_verify_mode;
					regs.rdata[fpec_pkg::BIT_PROG_VERIFY]  = program_verify_mode;
					regs.rdata[fpec_pkg::BIT_E]            = erase_mode;
					regs.rdata[fpec_pkg::BIT_P]            = program_mode;
				end
			end
			fpec_pkg::ADDR_STATUS:
			begin
				if (ctl_open)
					regs.rdata[fpec_pkg::BIT_ERROR] = flash_error_flag;
			end
			fpec_pkg::ADDR_EBS:
			begin
				if (ctl_open)
					regs.rdata[6:0] = erase_block_select;
			end
			fpec_pkg::ADDR_ACCEN:
				regs.rdata[fpec_pkg::BIT_ACCEN] = control_access_enable;
			fpec_pkg::ADDR_IRQST:
				regs.rdata[1:0] = irq_status;
			fpec_pkg::ADDR_IRQMSK:
				regs.rdata[1:0] = irq_mask;
			default:
				regs.rdata = 32'h00000000;
		endcase
	end

endmodule : fpec_top

// ==== bench/fpec_chk.sv ====
// checker for the flash program/erase control ports
`timescale 1ns/1ps
module fpec_chk
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	// flash array
	input wire logic        array_fault,
	input wire logic        program_mode,
	input wire logic        erase_mode,
	input wire logic        program_setup_state,
	input wire logic        erase_setup_state,
	input wire logic [6:0]  erase_block_select,
	input wire logic        error_protect
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	ready_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready not after one wait state");
	prog_gate_a: assert property ($rose(program_mode) |-> $past(program_setup_state))
		else $error("program mode without setup");
	erase_gate_a: assert property ($rose(erase_mode) |-> $past(erase_setup_state))
		else $error("erase mode without setup");
	fault_flag_a: assert property ((program_mode || erase_mode) && array_fault
		|-> ##[1:2] error_protect) else $error("fault not flagged");
	protect_block_a: assert property (error_protect |=> !program_mode && !erase_mode)
		else $error("mode active under protection");
	protect_hold_a: assert property (error_protect |=> error_protect)
		else $error("protection dropped");
	mode_rsvd_a: assert property (pready && !pwrite && paddr == 32'h0 |-> !prdata[7])
		else $error("mode bit 7 reads one");
	status_rsvd_a: assert property (pready && !pwrite && paddr == 32'h4
		|-> prdata[6:0] == 7'h00) else $error("status low bits nonzero");
	ebs_single_a: assert property ($countones(erase_block_select) <= 1)
		else $error("several blocks selected");
endmodule : fpec_chk

bind fpec_top fpec_chk fpec_chk_i
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.array_fault(array_fault), .program_mode(program_mode), .erase_mode(erase_mode),
	.program_setup_state(program_setup_state), .erase_setup_state(erase_setup_state),
	.erase_block_select(erase_block_select), .error_protect(error_protect)
);

// ==== bench/test_flash_program_erase_control.sv ====
// self-checking bench for the flash program/erase control block
`timescale 1ns/1ps
module test_flash_program_erase_control;
	// apb side
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rdat;
	logic        rerr;
	// array side
	logic        array_fault, pm, em, pss, ess, pvm, evm, ep, irq;
	logic [6:0]  ebs;
	int          bad_count, n_compared, cyc;

	fpec_top fpec_top_i
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .array_fault(array_fault),
		.program_mode(pm), .erase_mode(em), .program_setup_state(pss),
		.erase_setup_state(ess), .program_verify_mode(pvm), .erase_verify_mode(evm),
		.erase_block_select(ebs), .error_protect(ep), .irq(irq)
	);

	initial
	begin
		pclk = 1'h0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// request held until pready is seen high at a rising edge, answer taken there
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= {24'h000000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
		repeat (2) @(negedge pclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rdat, e);
	endtask : rd

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			end_sim;
		end
	end

	initial
	begin
		{psel, penable, pwrite, array_fault, presetn} = 5'h00;
		paddr  = 32'h0;
		pwdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		wr(fpec_pkg::ADDR_MODE, 32'h40);
		rd(fpec_pkg::ADDR_MODE, 32'h0);
		wr(fpec_pkg::ADDR_ACCEN, 32'h80);
		wr(fpec_pkg::ADDR_MODE, 32'h3F);
		rd(fpec_pkg::ADDR_MODE, 32'h0);
		wr(fpec_pkg::ADDR_EBS, 32'h01);
		rd(fpec_pkg::ADDR_EBS, 32'h0);
		wr(fpec_pkg::ADDR_MODE, 32'hC0);
		rd(fpec_pkg::ADDR_MODE, 32'h40);
		wr(fpec_pkg::ADDR_EBS, 32'h04);
		rd(fpec_pkg::ADDR_EBS, 32'h04);
		chk({25'h0, ebs}, 32'h04);
		wr(fpec_pkg::ADDR_MODE, 32'h00);
		rd(fpec_pkg::ADDR_EBS, 32'h0);
		chk({25'h0, ebs}, 32'h0);
		wr(fpec_pkg::ADDR_MODE, 32'h40);
		wr(fpec_pkg::ADDR_MODE, 32'h41);
		chk({31'h0, pm}, 32'h0);
		wr(fpec_pkg::ADDR_MODE, 32'h50);
		wr(fpec_pkg::ADDR_MODE, 32'h51);
		chk({30'h0, pm, pss}, 32'h3);
		wr(fpec_pkg::ADDR_MODE, 32'h50);
		chk({31'h0, pm}, 32'h0);
		wr(fpec_pkg::ADDR_MODE, 32'h60);
		wr(fpec_pkg::ADDR_MODE, 32'h62);
		chk({30'h0, em, ess}, 32'h3);
		wr(fpec_pkg::ADDR_MODE, 32'h40);
		chk({30'h0, em, ess}, 32'h0);
		wr(fpec_pkg::ADDR_MODE, 32'h48);
		chk({30'h0, evm, pvm}, 32'h2);
		wr(fpec_pkg::ADDR_MODE, 32'h44);
		chk({30'h0, evm, pvm}, 32'h1);
		wr(fpec_pkg::ADDR_STATUS, 32'hFF);
		rd(fpec_pkg::ADDR_STATUS, 32'h0);
		apb(1'h0, 8'h18, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		wr(fpec_pkg::ADDR_MODE, 32'h50);
		wr(fpec_pkg::ADDR_MODE, 32'h51);
		@(posedge pclk);
		array_fault <= 1'h1;
		@(posedge pclk);
		array_fault <= 1'h0;
		repeat (2) @(negedge pclk);
		chk({30'h0, ep, pm}, 32'h2);
		rd(fpec_pkg::ADDR_STATUS, 32'h80);
		chk({31'h0, irq}, 32'h0);
		wr(fpec_pkg::ADDR_IRQMSK, 32'h01);
		chk({31'h0, irq}, 32'h1);
		wr(fpec_pkg::ADDR_IRQST, 32'h01);
		chk({31'h0, irq}, 32'h0);
		rd(fpec_pkg::ADDR_IRQST, 32'h02);
		wr(fpec_pkg::ADDR_MODE, 32'h50);
		wr(fpec_pkg::ADDR_MODE, 32'h51);
		chk({31'h0, pm}, 32'h0);
		// protection is left only through reset
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		@(negedge pclk);
		chk({31'h0, ep}, 32'h0);
		rd(fpec_pkg::ADDR_STATUS, 32'h0);
		end_sim;
	end
endmodule : test_flash_program_erase_control
